// ### arc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none

// prescaler: one tick out per 1, 2, 4, 8 or 16 source ticks
module arc_clk_div (
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_src_tick,
    input  wire logic [2:0] i_div_sel,
    output logic            o_tick
);

    logic [3:0] count;
    wire  [3:0] limit;
    wire  [4:0] pow;

    assign pow   = 5'(5'h01 << i_div_sel[1:0]);
    // top bit set means divide by 16 whatever the low bits hold
    assign limit = i_div_sel[2] ? arc_pkg::DIV_MAX_LIMIT : 4'(pow - 5'h01);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            count  <= 4'h0;
            o_tick <= 1'b0;
        end else if (i_src_tick && count >= limit) begin
            count  <= 4'h0;
            o_tick <= 1'b1;
        end else if (i_src_tick) begin
            count  <= count + 4'h1;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
        end
    end

endmodule // arc_clk_div

`default_nettype wire

// ### arc_core.sv
`timescale 1ns/1ps
`default_nettype none

module arc_core (
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_osc_tick,
    input  wire logic       i_conv_done,
    input  wire logic [9:0] i_conv_result,
    output logic            o_adc_clk_en,
    output logic            o_conv_start,
    output logic            o_power_down,
    output logic      [4:0] o_channel,
    output logic            o_conv_irq
);

    typedef enum logic {ARC_IDLE, ARC_BUSY} arc_state_e;

    arc_state_e state;
    arc_state_e next_state;

    logic       conversion_complete_flag;
    logic       conversion_irq_enable;
    logic       continuous_convert;
    logic [4:0] channel_select;
    logic [2:0] clock_divide_select;
    logic       input_clock_select;
    logic [1:0] justify_mode;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic       pair_lock;
    logic [9:0] last_res;

    // address decode
    wire sel_sc   = (i_addr == arc_pkg::SC_OFFSET);
    wire sel_high = (i_addr == arc_pkg::HIGH_OFFSET);
    wire sel_low  = (i_addr == arc_pkg::LOW_OFFSET);
    wire sel_clk  = (i_addr == arc_pkg::CLK_OFFSET);

    wire wr_sc    = i_wr && sel_sc;
    wire wr_clk   = i_wr && sel_clk;
    wire rd_high  = i_rd && sel_high;
    wire rd_low   = i_rd && sel_low;
    wire rd_data  = rd_high || rd_low;

    // justified formats carry the read interlock, truncation does not
    wire justified = (justify_mode != arc_pkg::MODE_TRUNC);
    wire conv_end  = i_conv_done && (state == ARC_BUSY);
    // a high read in the same cycle also blocks the load so the pair stays coherent
    wire load_res  = conv_end && (!justified || (!pair_lock && !rd_high));
    wire start_req = wr_sc && (i_wdata[arc_pkg::SC_CHAN_MSB:0] != arc_pkg::CHAN_POWER_OFF);
    wire cont_next = conv_end && continuous_convert && !wr_sc;

    // result formatting; unused channels pass through whatever the converter gives
    wire       res_msb    = (justify_mode == arc_pkg::MODE_SIGNED) ? ~i_conv_result[9] : i_conv_result[9];
    wire [7:0] left_high  = {res_msb, i_conv_result[8:2]};
    wire [7:0] left_low   = {i_conv_result[1:0], 6'h00};
    wire [7:0] right_high = {6'h00, i_conv_result[9:8]};
    wire [7:0] right_low  = i_conv_result[7:0];
    wire [7:0] trunc_low  = i_conv_result[9:2];

    // format decode
    wire [7:0] next_high = (justify_mode == arc_pkg::MODE_TRUNC) ? 8'h00 :
                           (justify_mode == arc_pkg::MODE_RIGHT) ? right_high : left_high;
    wire [7:0] next_low  = (justify_mode == arc_pkg::MODE_TRUNC) ? trunc_low :
                           (justify_mode == arc_pkg::MODE_RIGHT) ? right_low : left_low;

    // read mux; complete flag reads zero in interrupt mode
    wire [7:0] sc_read  = {conversion_complete_flag && !conversion_irq_enable, conversion_irq_enable,
                           continuous_convert, channel_select};
    wire [7:0] clk_read = {clock_divide_select, input_clock_select, justify_mode, 2'h0};
    wire [7:0] rd_mux   = sel_sc   ? sc_read :
                          sel_high ? result_high_byte :
                          sel_low  ? result_low_byte :
                          sel_clk  ? clk_read : 8'h00;

    // converter input clock source
    wire src_tick = input_clock_select ? 1'b1 : i_osc_tick;

    assign o_channel = channel_select;

    arc_clk_div u_div (
        .i_sys_clk  (i_sys_clk),
        .i_resetn   (i_resetn),
        .i_src_tick (src_tick),
        .i_div_sel  (clock_divide_select),
        .o_tick     (o_adc_clk_en)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

    // status_control_register
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            conversion_irq_enable <= arc_pkg::IEN_RESET;
            continuous_convert    <= arc_pkg::CONT_RESET;
            channel_select        <= arc_pkg::CHAN_RESET;
            o_power_down          <= 1'b1;
        end else if (wr_sc) begin
            conversion_irq_enable <= i_wdata[arc_pkg::SC_IEN_BIT];
            continuous_convert    <= i_wdata[arc_pkg::SC_CONT_BIT];
            channel_select        <= i_wdata[arc_pkg::SC_CHAN_MSB:0];
            o_power_down          <= !start_req;
        end
    end

    // conversion_clock_control
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            clock_divide_select <= arc_pkg::DIV_RESET;
            input_clock_select  <= arc_pkg::ICLS_RESET;
            justify_mode        <= arc_pkg::MODE_RESET;
        end else if (wr_clk) begin
            clock_divide_select <= i_wdata[arc_pkg::CLK_DIV_MSB:arc_pkg::CLK_DIV_LSB];
            input_clock_select  <= i_wdata[arc_pkg::CLK_ICLS_BIT];
            justify_mode        <= i_wdata[arc_pkg::CLK_MODE_MSB:arc_pkg::CLK_MODE_LSB];
        end
    end

    // conversion sequencing
    always_comb begin
        next_state = state;
        case (state)
            ARC_IDLE: begin
                if (start_req) begin
                    next_state = ARC_BUSY;
                end
            end
            ARC_BUSY: begin
                if (wr_sc) begin
                    next_state = start_req ? ARC_BUSY : ARC_IDLE;
                end else if (conv_end && !continuous_convert) begin
                    next_state = ARC_IDLE;
                end
            end
            default: begin
                next_state = ARC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            state        <= ARC_IDLE;
            o_conv_start <= 1'b0;
        end else begin
            state        <= next_state;
            o_conv_start <= start_req || cont_next;
        end
    end

    // result registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            result_high_byte <= 8'h00;
            result_low_byte  <= 8'h00;
        end else if (load_res) begin
            result_high_byte <= next_high;
            result_low_byte  <= next_low;
        end
    end

    // read interlock: high read locks in justified formats only, low read releases
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            pair_lock <= 1'b0;
        end else if (rd_high && justified) begin
            pair_lock <= 1'b1;
        end else if (rd_low) begin
            pair_lock <= 1'b0;
        end
    end

    // completion flag and interrupt; a set beats a clear in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            conversion_complete_flag <= 1'b0;
            o_conv_irq               <= 1'b0;
        end else begin
            if (conv_end && !conversion_irq_enable) begin
                conversion_complete_flag <= 1'b1;
            end else if (rd_data) begin
                conversion_complete_flag <= 1'b0;
            end
            if (conv_end && conversion_irq_enable) begin
                o_conv_irq <= 1'b1;
            end else if (rd_data || wr_sc) begin
                o_conv_irq <= 1'b0;
            end
        end
    end

    // sample of the converter result, read only by the checks below
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            last_res <= 10'h000;
        end else begin
            last_res <= i_conv_result;
        end
    end

    sequence high_read_s;
        rd_high && justified;
    endsequence

    sequence pair_pending_s;
        pair_lock && !rd_low;
    endsequence

    left_format_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        load_res && justify_mode == arc_pkg::MODE_LEFT |=>
        result_high_byte == last_res[9:2] && result_low_byte == {last_res[1:0], 6'h00})
        else $error("left justified layout wrong");

    right_format_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        load_res && justify_mode == arc_pkg::MODE_RIGHT |=>
        result_high_byte == {6'h00, last_res[9:8]} && result_low_byte == last_res[7:0])
        else $error("right justified layout wrong");

    signed_format_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        load_res && justify_mode == arc_pkg::MODE_SIGNED |=>
        result_high_byte == {~last_res[9], last_res[8:2]} && result_low_byte[5:0] == 6'h00)
        else $error("signed layout wrong");

    trunc_format_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        conv_end && justify_mode == arc_pkg::MODE_TRUNC |=>
        result_high_byte == 8'h00 && result_low_byte == last_res[9:2])
        else $error("truncation result not loaded");

    pair_freeze_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        high_read_s ##1 pair_pending_s |=> $stable(result_low_byte) && $stable(result_high_byte))
        else $error("result changed while read pair pending");

    lock_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        high_read_s ##1 (!rd_low [*2]) |-> pair_lock)
        else $error("interlock lost before low read");

    conversion_complete_flag_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        conv_end && !conversion_irq_enable |=> conversion_complete_flag ##0
        (rd_data or (##1 conversion_complete_flag)))
        else $error("complete flag not held");

    irq_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (rd_data || wr_sc) && !conv_end |=> !o_conv_irq)
        else $error("interrupt not dropped");

    irq_raise_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        conv_end && conversion_irq_enable |=>
        o_conv_irq && (!conversion_complete_flag || $past(conversion_complete_flag)))
        else $error("interrupt not raised");

    continuous_restart_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        cont_next |=> o_conv_start && state == ARC_BUSY)
        else $error("continuous restart missing");

    power_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        wr_sc && i_wdata[4:0] == arc_pkg::CHAN_POWER_OFF |=> o_power_down && !o_conv_start)
        else $error("power down not applied");

    bus_clock_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (input_clock_select && clock_divide_select == 3'h0)[*3] |-> o_adc_clk_en)
        else $error("bus clock divide by one broken");

    sequence locked_end_s;
        conv_end && justified && pair_lock;
    endsequence

    sequence div_tick_s;
        o_adc_clk_en && clock_divide_select != 3'h0;
    endsequence

    lock_release_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        rd_low |=>
        !pair_lock)
        else $error("interlock not released by low read");

    trunc_no_lock_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !justified && !pair_lock |=>
        !pair_lock)
        else $error("truncation format set the interlock");

    locked_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        locked_end_s |=>
        $stable(result_high_byte) && $stable(result_low_byte))
        else $error("locked result overwritten");

    power_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        wr_sc && i_wdata[4:0] != arc_pkg::CHAN_POWER_OFF |=>
        !o_power_down && o_conv_start)
        else $error("converter not powered and started");

    osc_source_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !input_clock_select && !i_osc_tick |=>
        !o_adc_clk_en)
        else $error("clock pulse without oscillator tick");

    tick_gap_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        div_tick_s |=>
        !o_adc_clk_en)
        else $error("divided clock pulses back to back");

    single_shot_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        conv_end && !continuous_convert && !wr_sc |=>
        state == ARC_IDLE && !o_conv_start)
        else $error("single conversion restarted");

    flag_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        rd_data && !conv_end |=>
        !conversion_complete_flag)
        else $error("complete flag not cleared by data read");

endmodule // arc_core

`default_nettype wire

// ### arc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

module arc_core_tb;
    logic       i_sys_clk;
    logic       i_resetn;
    logic [2:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic [7:0] o_rdata;
    logic       i_osc_tick;
    logic       i_conv_done;
    logic [9:0] i_conv_result;
    logic       o_adc_clk_en;
    logic       o_conv_start;
    logic       o_power_down;
    logic [4:0] o_channel;
    logic       o_conv_irq;
    logic [1:0] osc_cnt;
    logic [7:0] d;
    logic [9:0] res_a;
    logic [15:0] f;
    int         error_cnt;
    int         n_tests;

    arc_core dut (
        .i_sys_clk    (i_sys_clk),
        .i_resetn     (i_resetn),
        .i_addr       (i_addr),
        .i_wdata      (i_wdata),
        .i_wr         (i_wr),
        .i_rd         (i_rd),
        .o_rdata      (o_rdata),
        .i_osc_tick   (i_osc_tick),
        .i_conv_done  (i_conv_done),
        .i_conv_result(i_conv_result),
        .o_adc_clk_en (o_adc_clk_en),
        .o_conv_start (o_conv_start),
        .o_power_down (o_power_down),
        .o_channel    (o_channel),
        .o_conv_irq   (o_conv_irq)
    );

    always #20 i_sys_clk = ~i_sys_clk;

    // oscillator tick once every three system cycles
    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            osc_cnt    <= 2'h0;
            i_osc_tick <= 1'b0;
        end else begin
            osc_cnt    <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
            i_osc_tick <= (osc_cnt == 2'h2);
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        #1;
        @(posedge i_sys_clk);
    endtask

    // strobe edge, then data stand in the following cycle only
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
        @(posedge i_sys_clk);
    endtask

    task automatic done(input logic [9:0] r);
        i_conv_done   <= 1'b1;
        i_conv_result <= r;
        @(posedge i_sys_clk);
        i_conv_done   <= 1'b0;
        i_conv_result <= ~r;
        #1;
    endtask

    // start a conversion on channel 0 and finish it with result r
    task automatic conv(input logic [9:0] r);
        i_wr    <= 1'b1;
        i_addr  <= 3'h0;
        i_wdata <= 8'h00;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        #1;
        check({7'h0, o_conv_start}, 8'h01);
        check({7'h0, o_power_down}, 8'h00);
        @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        done(r);
        @(posedge i_sys_clk);
    endtask

    function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
        case (m)
            2'h0:    fmt = {8'h00, r[9:2]};
            2'h1:    fmt = {6'h00, r[9:8], r[7:0]};
            2'h2:    fmt = {r[9:2], r[1:0], 6'h00};
            default: fmt = {~r[9], r[8:2], r[1:0], 6'h00};
        endcase
    endfunction

    // distance in cycles between two converter clock pulses
    task automatic gap(input logic [7:0] exp);
        int k;
        int g;
        k = 0;
        g = 0;
        repeat (2) begin
            do begin @(negedge i_sys_clk); k++; end while (o_adc_clk_en !== 1'b1 && k < 400);
        end
        do begin @(negedge i_sys_clk); g++; end while (o_adc_clk_en !== 1'b1 && g < 200);
        check(8'(g), exp);
        @(posedge i_sys_clk);
    endtask

    initial begin
        i_sys_clk     = 1'b0;
        i_resetn      = 1'b0;
        i_addr        = 3'h0;
        i_wdata       = 8'h00;
        i_wr          = 1'b0;
        i_rd          = 1'b0;
        i_conv_done   = 1'b0;
        i_conv_result = 10'h000;
        error_cnt     = 0;
        n_tests       = 0;
        repeat (6) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        @(posedge i_sys_clk);
        check({7'h0, o_power_down}, 8'h01);
        check({3'h0, o_channel}, 8'h1f);
        rd(3'h3, d); check(d, 8'h04);
        rd(3'h0, d); check(d, 8'h1f);
        wr(3'h5, 8'hff);
        rd(3'h5, d); check(d, 8'h00);
        wr(3'h3, 8'hff);
        rd(3'h3, d); check(d, 8'hfc);
        // every format code with two result patterns
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 2; p++) begin
                res_a = p ? 10'h2b5 : 10'h14a;
                f = fmt(2'(m), res_a);
                wr(3'h3, {3'h0, 1'b1, 2'(m), 2'h0});
                conv(res_a);
                rd(3'h1, d); check(d, f[15:8]);
                rd(3'h2, d); check(d, f[7:0]);
            end
        end
        // right justified interlock
        wr(3'h3, 8'h04);
        conv(10'h1c3);
        rd(3'h1, d); check(d, 8'h01);
        conv(10'h23c);
        rd(3'h2, d); check(d, 8'hc3);
        rd(3'h1, d); check(d, 8'h01);
        rd(3'h2, d); check(d, 8'hc3);
        conv(10'h23c);
        rd(3'h1, d); check(d, 8'h02);
        rd(3'h2, d); check(d, 8'h3c);
        // truncation has no interlock
        wr(3'h3, 8'h00);
        conv(10'h0f0);
        rd(3'h1, d); check(d, 8'h00);
        conv(10'h3fc);
        rd(3'h2, d); check(d, 8'hff);
        // complete flag without interrupt enable
        conv(10'h155);
        rd(3'h0, d); check(d, 8'h80);
        rd(3'h2, d); check(d, 8'h55);
        rd(3'h0, d); check(d, 8'h00);
        // interrupt raised, dropped by control write, then by data read
        wr(3'h0, 8'h40);
        repeat (2) @(posedge i_sys_clk);
        done(10'h001);
        check({7'h0, o_conv_irq}, 8'h01);
        rd(3'h0, d); check(d, 8'h40);
        check({7'h0, o_conv_irq}, 8'h01);
        wr(3'h0, 8'h40);
        check({7'h0, o_conv_irq}, 8'h00);
        done(10'h002);
        check({7'h0, o_conv_irq}, 8'h01);
        rd(3'h2, d); check(d, 8'h00);
        check({7'h0, o_conv_irq}, 8'h00);
        // continuous mode restarts after each result
        wr(3'h0, 8'h25);
        check({3'h0, o_channel}, 8'h05);
        repeat (2) @(posedge i_sys_clk);
        done(10'h3ff);
        check({7'h0, o_conv_start}, 8'h01);
        wr(3'h0, 8'h1f);
        check({7'h0, o_power_down}, 8'h01);
        // prescaler on bus clock, then on oscillator ticks
        for (int v = 0; v < 8; v++) begin
            wr(3'h3, {3'(v), 1'b1, 4'h4});
            gap((v > 3) ? 8'd16 : 8'(1 << v));
        end
        wr(3'h3, 8'h04);
        gap(8'd3);
        wr(3'h3, 8'h24);
        gap(8'd6);
        finish_test();
    end

    initial begin
        #(40 * 20000);
        error_cnt++;
        finish_test();
    end
endmodule // arc_core_tb

`default_nettype wire

// ### arc_pkg.sv
package arc_pkg;

    // register offsets on the plain register port
    localparam logic [2:0] SC_OFFSET   = 3'h0;
    localparam logic [2:0] HIGH_OFFSET = 3'h1;
    localparam logic [2:0] LOW_OFFSET  = 3'h2;
    localparam logic [2:0] CLK_OFFSET  = 3'h3;

    // status_control_register fields
    localparam int SC_CONVERSION_COMPLETE_FLAG_BIT = 7;
    localparam int SC_IEN_BIT  = 6;
    localparam int SC_CONT_BIT = 5;
    localparam int SC_CHAN_MSB = 4;

    // conversion_clock_control fields
    localparam int CLK_DIV_MSB  = 7;
    localparam int CLK_DIV_LSB  = 5;
    localparam int CLK_ICLS_BIT = 4;
    localparam int CLK_MODE_MSB = 3;
    localparam int CLK_MODE_LSB = 2;

    // justification codes
    localparam logic [1:0] MODE_TRUNC  = 2'h0;
    localparam logic [1:0] MODE_RIGHT  = 2'h1;
    localparam logic [1:0] MODE_LEFT   = 2'h2;
    localparam logic [1:0] MODE_SIGNED = 2'h3;

    // channel code that powers the converter down
    localparam logic [4:0] CHAN_POWER_OFF = 5'h1f;

    // values after reset
    localparam logic [4:0] CHAN_RESET     = 5'h1f;
    localparam logic       IEN_RESET      = 1'b0;
    localparam logic       CONT_RESET     = 1'b0;
    localparam logic [2:0] DIV_RESET      = 3'h0;
    localparam logic       ICLS_RESET     = 1'b0;
    localparam logic [1:0] MODE_RESET     = 2'h1;

    // prescaler terminal count for divide by 16
    localparam logic [3:0] DIV_MAX_LIMIT  = 4'hf;

endpackage
